// ---- design/pdmc_pkg.sv ----
// Package for the power-down mode controller: register map, field layout,
// reset values, state encoding and short timing counts.
// Assumes a 32-bit AXI4-Lite register bus and a single 20 MHz system clock.
package pdmc_pkg;

  // Register byte offsets
  localparam logic [31:0] PDMC_SYSCTL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] PDMC_STATUS_OFFSET = 32'h0000_0004;

  // Fields of system_control_reg
  localparam int PDMC_SOFT_STANDBY_SELECT_BIT = 7;
  localparam int PDMC_STS_LSB = 4;
  localparam int PDMC_RSTFLAG_BIT = 3;
  localparam int PDMC_NMI_EDGE_SELECT_BIT = 2;
  localparam int PDMC_HOSTEN_BIT = 1;
  localparam int PDMC_ONCHIP_RAM_ENABLE_BIT = 0;

  // Reset values of system_control_reg
  localparam logic [7:0] PDMC_SYSCTL_RESET = 8'h09;
  localparam logic PDMC_SOFT_STANDBY_SELECT_RESET = 1'b0;
  localparam logic [2:0] PDMC_STS_RESET = 3'h0;
  localparam logic PDMC_NMI_EDGE_SELECT_RESET = 1'b0;
  localparam logic PDMC_HOSTEN_RESET = 1'b0;
  localparam logic PDMC_ONCHIP_RAM_ENABLE_RESET = 1'b1;

  // Fields of the status register
  localparam int PDMC_STAT_STATE_LSB = 0;
  localparam int PDMC_STAT_HW_STANDBY_PIN_N_BIT = 4;
  localparam int PDMC_STAT_RES_BIT = 5;
  localparam int PDMC_STAT_NMI_BIT = 6;
  localparam int PDMC_STAT_MASK_BIT = 7;

  // Settling select codes
  localparam logic [2:0] PDMC_STS_8K = 3'h0;
  localparam logic [2:0] PDMC_STS_16K = 3'h1;
  localparam logic [2:0] PDMC_STS_32K = 3'h2;
  localparam logic [2:0] PDMC_STS_64K = 3'h3;
  localparam logic [2:0] PDMC_STS_128K = 3'h4;
  localparam logic [2:0] PDMC_STS_1K = 3'h5;
  localparam int PDMC_SETTLE_1K_STATES = 1024;
  localparam int PDMC_SETTLE_CNT_W = 18;

  // AXI responses
  localparam logic [1:0] PDMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PDMC_RESP_SLVERR = 2'h2;

  // Pin synchroniser lane count: nmi, init, standby, irq pins 7..0
  localparam int PDMC_SYNC_W = 11;

  // Gray code along run, sleep, standby, settle; then hw standby, reset hold
  typedef enum logic [2:0] {
    PDMC_RUN = 3'h0,
    PDMC_SLEEP = 3'h1,
    PDMC_SW_HW_STANDBY_PIN_N = 3'h3,
    PDMC_SETTLE = 3'h2,
    PDMC_HW_HW_STANDBY_PIN_N = 3'h6,
    PDMC_INIT_HOLD = 3'h7
  } pdmc_state_t;

  // Controls toward CPU, clock and support modules
  typedef struct packed {
    logic osc_enable;
    logic sysclk_enable;
    logic cpu_halt;
    logic cpu_init;
    logic module_halt;
    logic module_init;
    logic io_hiz;
    logic int_seq_start;
    logic reset_seq_start;
  } pdmc_ctrl_t;

  // Whole module state
  typedef struct packed {
    pdmc_state_t fsm;
    logic [PDMC_SETTLE_CNT_W-1:0] settle_cnt;
    logic nmi_prev;
    logic mask_at_sleep;
    logic soft_standby_select;
    logic [2:0] settle_time_select;
    logic nmi_edge_select;
    logic host_port_enable;
    logic onchip_ram_enable;
    logic int_seq_start;
    logic reset_seq_start;
    logic aw_have;
    logic [31:0] aw_addr;
    logic w_have;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pdmc_regs_t;

endpackage : pdmc_pkg

// ---- design/pdmc_sync2.sv ----
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes idle-high pins; lanes reset to ones.
`timescale 1ns/100ps
module pdmc_sync2 #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // First stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;

endmodule : pdmc_sync2

// ---- design/pdmc_power_down.sv ----
// Power-down mode controller: sleep, software standby with settling wait,
// hardware standby, and the AXI4-Lite system control register.
// Assumes the CPU pulses sleep_exec for one aclk cycle when it executes
// sleep, and that the oscillator clock is modelled by aclk gated by osc_enable.
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/100ps
module pdmc_power_down #(
  parameter int unsigned SETTLE_8K_STATES = 8192,
  parameter int unsigned SETTLE_16K_STATES = 16384,
  parameter int unsigned SETTLE_32K_STATES = 32768,
  parameter int unsigned SETTLE_64K_STATES = 65536,
  parameter int unsigned SETTLE_128K_STATES = 131072
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sleep_exec,
  input wire logic cpu_int_mask,
  input wire logic module_irq,
  input wire logic [7:0] irq_enable,
  input wire logic [7:0] ext_irq_pin_n,
  input wire logic nmi_pin,
  input wire logic hard_init_pin_n,
  input wire logic hw_standby_pin_n,
  output pdmc_pkg::pdmc_ctrl_t ctrl,
  output logic onchip_ram_enable,
  output logic nmi_edge_select,
  output logic host_port_enable,
  output logic [2:0] power_mode
);

  pdmc_pkg::pdmc_regs_t state_reg;
  pdmc_pkg::pdmc_regs_t state_next;

  logic [pdmc_pkg::PDMC_SYNC_W-1:0] pins_sync;
  logic nmi_s;
  logic init_n_s;
  logic hw_standby_pin_n_n_s;
  logic [7:0] irq_pin_s;
  logic nmi_event;
  logic [7:0] irq_req;
  logic sleep_wake;
  logic hw_standby_pin_n_wake;
  logic [pdmc_pkg::PDMC_SETTLE_CNT_W-1:0] settle_load;
  int unsigned settle_states;
  logic [7:0] sysctl_value;
  logic [31:0] status_value;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic in_init;

  pdmc_sync2 #(
    .W(pdmc_pkg::PDMC_SYNC_W)
  ) u_pin_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({nmi_pin, hard_init_pin_n, hw_standby_pin_n, ext_irq_pin_n}),
    .sync_out(pins_sync)
  );

  assign nmi_s = pins_sync[10];
  assign init_n_s = pins_sync[9];
  assign hw_standby_pin_n_n_s = pins_sync[8];
  assign irq_pin_s = ~pins_sync[7:0];

  // Edge follows the select bit; the sleep handler may flip it first
  assign nmi_event = state_reg.nmi_edge_select ? (nmi_s & ~state_reg.nmi_prev)
                                               : (~nmi_s & state_reg.nmi_prev);
  // Disabled sources never request
  assign irq_req = irq_pin_s & irq_enable;
  // Mask taken at sleep entry leaves only NMI
  assign sleep_wake = nmi_event |
                      (~state_reg.mask_at_sleep & (module_irq | (|irq_req)));
  // Standby wake sources; IRQ6 includes the key input lane
  assign hw_standby_pin_n_wake = nmi_event | (|irq_req[2:0]) | irq_req[6];

  always_comb begin
    settle_states = SETTLE_128K_STATES;
    case (state_reg.settle_time_select)
      pdmc_pkg::PDMC_STS_8K: settle_states = SETTLE_8K_STATES;
      pdmc_pkg::PDMC_STS_16K: settle_states = SETTLE_16K_STATES;
      pdmc_pkg::PDMC_STS_32K: settle_states = SETTLE_32K_STATES;
      pdmc_pkg::PDMC_STS_64K: settle_states = SETTLE_64K_STATES;
      pdmc_pkg::PDMC_STS_128K: settle_states = SETTLE_128K_STATES;
      pdmc_pkg::PDMC_STS_1K:
        settle_states = unsigned'(pdmc_pkg::PDMC_SETTLE_1K_STATES);
      // Unused codes fall back to the longest wait, the safe side
      default: settle_states = SETTLE_128K_STATES;
    endcase
    settle_load = pdmc_pkg::PDMC_SETTLE_CNT_W'(settle_states - 1);
  end

  always_comb begin
    sysctl_value = 8'h00;
    sysctl_value[pdmc_pkg::PDMC_SOFT_STANDBY_SELECT_BIT] = state_reg.soft_standby_select;
    sysctl_value[pdmc_pkg::PDMC_STS_LSB +: 3] = state_reg.settle_time_select;
    sysctl_value[pdmc_pkg::PDMC_RSTFLAG_BIT] =
      pdmc_pkg::PDMC_SYSCTL_RESET[pdmc_pkg::PDMC_RSTFLAG_BIT];
    sysctl_value[pdmc_pkg::PDMC_NMI_EDGE_SELECT_BIT] = state_reg.nmi_edge_select;
    sysctl_value[pdmc_pkg::PDMC_HOSTEN_BIT] = state_reg.host_port_enable;
    sysctl_value[pdmc_pkg::PDMC_ONCHIP_RAM_ENABLE_BIT] = state_reg.onchip_ram_enable;
    status_value = 32'h0000_0000;
    status_value[pdmc_pkg::PDMC_STAT_STATE_LSB +: 3] = state_reg.fsm;
    status_value[pdmc_pkg::PDMC_STAT_HW_STANDBY_PIN_N_BIT] = hw_standby_pin_n_n_s;
    status_value[pdmc_pkg::PDMC_STAT_RES_BIT] = init_n_s;
    status_value[pdmc_pkg::PDMC_STAT_NMI_BIT] = nmi_s;
    status_value[pdmc_pkg::PDMC_STAT_MASK_BIT] = state_reg.mask_at_sleep;
  end

  assign s_axi_awready = ~state_reg.aw_have & ~state_reg.bvalid;
  assign s_axi_wready = ~state_reg.w_have & ~state_reg.bvalid;
  assign s_axi_arready = ~state_reg.rvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign in_init = (state_reg.fsm == pdmc_pkg::PDMC_HW_HW_STANDBY_PIN_N) |
                   (state_reg.fsm == pdmc_pkg::PDMC_INIT_HOLD);

  always_comb begin
    state_next = state_reg;
    state_next.int_seq_start = 1'b0;
    state_next.reset_seq_start = 1'b0;
    state_next.nmi_prev = nmi_s;

    // Bus write side; address and data accepted in either order
    if (aw_hs) begin
      state_next.aw_have = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
    end
    if (w_hs) begin
      state_next.w_have = 1'b1;
      state_next.w_byte = s_axi_wdata[7:0];
      state_next.w_lane0 = s_axi_wstrb[0];
    end
    if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
      state_next.aw_have = 1'b0;
      state_next.w_have = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = pdmc_pkg::PDMC_RESP_OKAY;
      if (state_reg.aw_addr == pdmc_pkg::PDMC_SYSCTL_OFFSET) begin
        if (state_reg.w_lane0 && !in_init) begin
          state_next.soft_standby_select = state_reg.w_byte[pdmc_pkg::PDMC_SOFT_STANDBY_SELECT_BIT];
          state_next.settle_time_select = state_reg.w_byte[pdmc_pkg::PDMC_STS_LSB +: 3];
          state_next.nmi_edge_select = state_reg.w_byte[pdmc_pkg::PDMC_NMI_EDGE_SELECT_BIT];
          state_next.host_port_enable = state_reg.w_byte[pdmc_pkg::PDMC_HOSTEN_BIT];
          state_next.onchip_ram_enable = state_reg.w_byte[pdmc_pkg::PDMC_ONCHIP_RAM_ENABLE_BIT];
        end
      end else if (state_reg.aw_addr != pdmc_pkg::PDMC_STATUS_OFFSET) begin
        state_next.bresp = pdmc_pkg::PDMC_RESP_SLVERR;
      end
    end
    if (state_reg.bvalid && s_axi_bready) begin
      state_next.bvalid = 1'b0;
    end

    // Bus read side
    if (state_reg.rvalid && s_axi_rready) begin
      state_next.rvalid = 1'b0;
    end
    if (ar_hs) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = pdmc_pkg::PDMC_RESP_OKAY;
      state_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == pdmc_pkg::PDMC_SYSCTL_OFFSET) begin
        state_next.rdata = {24'h00_0000, sysctl_value};
      end else if (s_axi_araddr == pdmc_pkg::PDMC_STATUS_OFFSET) begin
        state_next.rdata = status_value;
      end else begin
        state_next.rresp = pdmc_pkg::PDMC_RESP_SLVERR;
      end
    end

    // Mode sequencing; standby pin wins over everything, then init pin
    if (state_reg.settle_cnt != '0) begin
      state_next.settle_cnt = state_reg.settle_cnt - 1'b1;
    end
    case (state_reg.fsm)
      pdmc_pkg::PDMC_RUN: begin
        if (sleep_exec) begin
          state_next.mask_at_sleep = cpu_int_mask;
          state_next.fsm = state_reg.soft_standby_select ? pdmc_pkg::PDMC_SW_HW_STANDBY_PIN_N
                                                         : pdmc_pkg::PDMC_SLEEP;
        end
      end
      pdmc_pkg::PDMC_SLEEP: begin
        if (sleep_wake) begin
          state_next.fsm = pdmc_pkg::PDMC_RUN;
          state_next.int_seq_start = 1'b1;
        end
      end
      pdmc_pkg::PDMC_SW_HW_STANDBY_PIN_N: begin
        if (hw_standby_pin_n_wake) begin
          state_next.fsm = pdmc_pkg::PDMC_SETTLE;
          state_next.settle_cnt = settle_load;
        end
      end
      pdmc_pkg::PDMC_SETTLE: begin
        // Clock stays gated until the count runs out
        if (state_reg.settle_cnt == '0) begin
          state_next.fsm = pdmc_pkg::PDMC_RUN;
          state_next.int_seq_start = 1'b1;
        end
      end
      pdmc_pkg::PDMC_HW_HW_STANDBY_PIN_N: begin
        // Standby high restarts the oscillator; reset still held
        state_next.fsm = pdmc_pkg::PDMC_INIT_HOLD;
      end
      pdmc_pkg::PDMC_INIT_HOLD: begin
        if (init_n_s) begin
          state_next.fsm = pdmc_pkg::PDMC_RUN;
          state_next.reset_seq_start = 1'b1;
        end
      end
      default: state_next.fsm = pdmc_pkg::PDMC_INIT_HOLD;
    endcase
    if (!init_n_s && state_reg.fsm != pdmc_pkg::PDMC_HW_HW_STANDBY_PIN_N) begin
      state_next.fsm = pdmc_pkg::PDMC_INIT_HOLD;
      state_next.int_seq_start = 1'b0;
      state_next.reset_seq_start = 1'b0;
    end
    if (!hw_standby_pin_n_n_s) begin
      state_next.fsm = pdmc_pkg::PDMC_HW_HW_STANDBY_PIN_N;
      state_next.int_seq_start = 1'b0;
      state_next.reset_seq_start = 1'b0;
    end
    // Initialisation returns control bits to reset values; sw standby keeps them
    if (in_init) begin
      state_next.soft_standby_select = pdmc_pkg::PDMC_SOFT_STANDBY_SELECT_RESET;
      state_next.settle_time_select = pdmc_pkg::PDMC_STS_RESET;
      state_next.nmi_edge_select = pdmc_pkg::PDMC_NMI_EDGE_SELECT_RESET;
      state_next.host_port_enable = pdmc_pkg::PDMC_HOSTEN_RESET;
      state_next.onchip_ram_enable = pdmc_pkg::PDMC_ONCHIP_RAM_ENABLE_RESET;
      state_next.settle_cnt = '0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      state_reg.fsm <= pdmc_pkg::PDMC_RUN;
      state_reg.nmi_prev <= 1'b1;
      state_reg.soft_standby_select <= pdmc_pkg::PDMC_SOFT_STANDBY_SELECT_RESET;
      state_reg.settle_time_select <= pdmc_pkg::PDMC_STS_RESET;
      state_reg.nmi_edge_select <= pdmc_pkg::PDMC_NMI_EDGE_SELECT_RESET;
      state_reg.host_port_enable <= pdmc_pkg::PDMC_HOSTEN_RESET;
      state_reg.onchip_ram_enable <= pdmc_pkg::PDMC_ONCHIP_RAM_ENABLE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode decode from the state register
  always_comb begin
    ctrl = '0;
    ctrl.int_seq_start = state_reg.int_seq_start;
    ctrl.reset_seq_start = state_reg.reset_seq_start;
    case (state_reg.fsm)
      pdmc_pkg::PDMC_RUN: begin
        ctrl.osc_enable = 1'b1;
        ctrl.sysclk_enable = 1'b1;
      end
      pdmc_pkg::PDMC_SLEEP: begin
        ctrl.osc_enable = 1'b1;
        ctrl.sysclk_enable = 1'b1;
        ctrl.cpu_halt = 1'b1;
      end
      pdmc_pkg::PDMC_SW_HW_STANDBY_PIN_N, pdmc_pkg::PDMC_SETTLE: begin
        // CPU registers and ports held; modules initialised
        ctrl.osc_enable = (state_reg.fsm == pdmc_pkg::PDMC_SETTLE);
        ctrl.cpu_halt = 1'b1;
        ctrl.module_halt = 1'b1;
        ctrl.module_init = 1'b1;
      end
      pdmc_pkg::PDMC_HW_HW_STANDBY_PIN_N: begin
        ctrl.cpu_halt = 1'b1;
        ctrl.cpu_init = 1'b1;
        ctrl.module_halt = 1'b1;
        ctrl.module_init = 1'b1;
        ctrl.io_hiz = 1'b1;
      end
      pdmc_pkg::PDMC_INIT_HOLD: begin
        ctrl.osc_enable = 1'b1;
        ctrl.cpu_halt = 1'b1;
        ctrl.cpu_init = 1'b1;
        ctrl.module_halt = 1'b1;
        ctrl.module_init = 1'b1;
      end
      default: ctrl.cpu_halt = 1'b1;
    endcase
  end

  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;
  assign onchip_ram_enable = state_reg.onchip_ram_enable;
  assign nmi_edge_select = state_reg.nmi_edge_select;
  assign host_port_enable = state_reg.host_port_enable;
  assign power_mode = state_reg.fsm;

endmodule : pdmc_power_down

// ---- test/pdmc_power_down_asserts.sv ----
// Checker: power-mode relations at the controller's ports.
// Assumes a bind to pdmc_power_down; pins act three edges late.
`timescale 1ns/100ps
module pdmc_power_down_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_exec,
  input wire logic hard_init_pin_n,
  input wire logic hw_standby_pin_n,
  input wire pdmc_pkg::pdmc_ctrl_t ctrl,
  input wire logic [2:0] power_mode
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_SLEEP_ENTRY: assert property (power_mode == 3'h0 && sleep_exec
    |=> power_mode inside {3'h1, 3'h3, 3'h6, 3'h7}) else $error("sleep entry");
  AST_SLEEP_CTRL: assert property (power_mode == 3'h1
    |-> ctrl.sysclk_enable && ctrl.cpu_halt && !ctrl.module_halt) else $error("sleep ctrl");
  AST_SWSTBY_CTRL: assert property (power_mode == 3'h3 |-> !ctrl.osc_enable
    && !ctrl.sysclk_enable && ctrl.module_init && !ctrl.io_hiz) else $error("standby ctrl");
  AST_SETTLE_CTRL: assert property (power_mode == 3'h2
    |-> ctrl.osc_enable && !ctrl.sysclk_enable) else $error("settle ctrl");
  // Eight is the shortest settle count any build uses
  AST_SETTLE_MIN: assert property ($rose(power_mode == 3'h2)
    |-> (power_mode == 3'h2) [*8]) else $error("settle too short");
  AST_SETTLE_FROM: assert property ($rose(power_mode == 3'h2)
    |-> $past(power_mode) == 3'h3) else $error("settle source");
  AST_HW_ENTRY: assert property ((!hw_standby_pin_n) [*4]
    |-> power_mode == 3'h6 && ctrl.io_hiz) else $error("hw standby entry");
  AST_INIT_ENTRY: assert property ((hw_standby_pin_n && !hard_init_pin_n) [*4]
    |-> power_mode == 3'h7) else $error("init entry");
  AST_RESET_SEQ: assert property (ctrl.reset_seq_start
    |-> power_mode == 3'h0 && $past(power_mode) == 3'h7) else $error("reset seq");
  AST_INT_SEQ: assert property (ctrl.int_seq_start
    |-> power_mode == 3'h0 && $past(power_mode) inside {3'h1, 3'h2}) else $error("int seq");
  cover property (power_mode == 3'h1);
  cover property ($rose(power_mode == 3'h2));
  cover property ($rose(power_mode == 3'h6));
  cover property (ctrl.reset_seq_start);
endmodule : pdmc_power_down_asserts

bind pdmc_power_down pdmc_power_down_asserts u_asserts (.aclk(aclk), .aresetn(aresetn),
  .sleep_exec(sleep_exec), .hard_init_pin_n(hard_init_pin_n),
  .hw_standby_pin_n(hw_standby_pin_n), .ctrl(ctrl), .power_mode(power_mode));

// ---- test/pdmc_pin_model.sv ----
// Pin model: reset, standby, NMI and IRQ pins of the controller.
// Assumes its tasks are called just after a rising aclk edge.
`timescale 1ns/100ps
module pdmc_pin_model #(
  parameter int HOLD = 16
) (
  input wire logic aclk,
  output logic nmi_pin,
  output logic hard_init_pin_n,
  output logic hw_standby_pin_n,
  output logic [7:0] ext_irq_pin_n
);
  // Mode pins not modelled, so never changed
  initial begin
    nmi_pin = 1'h1;
    hard_init_pin_n = 1'h1;
    hw_standby_pin_n = 1'h1;
    ext_irq_pin_n = 8'hff;
  end
  task nmi_flip();
    @(posedge aclk);
    nmi_pin <= ~nmi_pin;
  endtask : nmi_flip
  task irq_set(input int i, input logic v);
    @(posedge aclk);
    ext_irq_pin_n[i] <= v;
  endtask : irq_set
  // Release only after the oscillator has had time to settle
  task init_set(input logic v);
    if (v) repeat (HOLD) @(posedge aclk);
    @(posedge aclk);
    hard_init_pin_n <= v;
  endtask : init_set
  // Reset low ahead of standby, unless a test skips it
  task hw_enter(input logic init_first);
    if (init_first) init_set(1'h0);
    repeat (2) @(posedge aclk);
    hw_standby_pin_n <= 1'h0;
  endtask : hw_enter
  // Standby rises with reset low; reset rises after settling
  task hw_leave();
    init_set(1'h0);
    @(posedge aclk);
    hw_standby_pin_n <= 1'h1;
    init_set(1'h1);
  endtask : hw_leave
endmodule : pdmc_pin_model

// ---- test/tb_top.sv ----
// Testbench: register access, sleep, software and hardware standby.
// Assumes short settling counts and the pin model driving all pins.
`timescale 1ns/100ps
module tb_top;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic sleep_exec = 1'h0, cpu_int_mask = 1'h0, module_irq = 1'h0;
  logic [7:0] irq_enable = 8'h47;
  logic [7:0] ext_irq_pin_n;
  logic nmi_pin, hard_init_pin_n, hw_standby_pin_n;
  logic onchip_ram_enable, nmi_edge_select, host_port_enable;
  logic [2:0] power_mode;
  pdmc_pkg::pdmc_ctrl_t ctrl;
  logic [31:0] seed = 32'h0000_19f6;
  logic lane0 = 1'h1;
  int fail_count = 0, n_checks = 0, n, bad, good;
  always #25 aclk = ~aclk;
  pdmc_power_down #(.SETTLE_8K_STATES(8), .SETTLE_16K_STATES(16), .SETTLE_32K_STATES(32),
    .SETTLE_64K_STATES(64), .SETTLE_128K_STATES(128)) u_pdmc_power_down (.*);
  pdmc_pin_model u_pins (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // Codes above 5 fall back to the 128K wait, 128 states here; code 5 stays at 1024
  function automatic int settle_n(input logic [2:0] c);
    if (c == 3'h5) return 1024;
    if (c > 3'h4) return 128;
    return 8 << c;
  endfunction : settle_n
  task automatic tally(input logic ok, input string m);
    n_checks++;
    if (ok !== 1'h1) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : tally
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e, input string m);
    tally(g === e, m);
  endtask : chk_word
  task automatic chk_bit(input logic g, input logic e, input string m);
    tally(g === e, m);
  endtask : chk_bit
  task automatic chk_mode(input logic [2:0] e, input string m);
    tally(power_mode === e, m);
  endtask : chk_mode
  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc
  task automatic wait_mode(input logic [2:0] m, output int cnt);
    cnt = 0;
    do begin
      @(posedge aclk);
      cnt++;
    end while (power_mode !== m && cnt < 2000);
    tally(cnt < 2000, "mode wait");
  endtask : wait_mode
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awprot <= seed[10:8];
    s_axi_wstrb <= {seed[13:11], lane0};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1 && t < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tally(t < 50, "write wait");
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arprot <= seed[16:14];
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    t = 0;
    do begin
      @(posedge aclk);
      t++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1 && t < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tally(t < 50, "read wait");
  endtask : axi_read
  task automatic slp();
    @(posedge aclk);
    sleep_exec <= 1'h1;
    @(posedge aclk);
    sleep_exec <= 1'h0;
    @(posedge aclk);
  endtask : slp
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  initial begin
    repeat (30000) @(posedge aclk);
    tally(1'h0, "timeout");
    results();
  end
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk_mode(3'h0, "reset mode");
    chk_word({23'h0, ctrl}, 32'h180, "reset ctrl");
    axi_read(32'h0, rd, rsp);
    chk_word(rd, 32'h9, "sysctl reset");
    axi_read(32'h10, rd, rsp);
    chk_word({rsp, rd[29:0]}, 32'h8000_0000, "unmapped");
    repeat (3) begin
      seed = xs(seed);
      axi_write(32'h0, {24'h0, seed[7:0]});
      axi_read(32'h0, rd, rsp);
      chk_word(rd, {24'h0, seed[7:0] | 8'h08}, "sysctl rw");
      chk_bit(nmi_edge_select, seed[2], "edge sel");
      chk_bit(host_port_enable, seed[1], "host en");
      chk_bit(onchip_ram_enable, seed[0], "ram en");
    end
    // Lane 0 strobe low must leave the register alone
    lane0 = 1'h0;
    axi_write(32'h0, {24'h0, ~seed[7:0]});
    lane0 = 1'h1;
    chk_word({30'h0, rsp}, 32'h0, "strobe off resp");
    axi_read(32'h0, rd, rsp);
    chk_word(rd, {24'h0, seed[7:0] | 8'h08}, "strobe off");
    axi_write(32'h8, 32'h0);
    chk_word({30'h0, rsp}, 32'h2, "write unmapped");
    done("regs");
    axi_write(32'h0, 32'h1);
    slp();
    chk_mode(3'h1, "sleep");
    chk_bit(ctrl.module_halt, 1'h0, "modules run");
    module_irq <= 1'h1;
    wait_mode(3'h0, n);
    chk_bit(ctrl.int_seq_start, 1'h1, "irq wake");
    module_irq <= 1'h0;
    cpu_int_mask <= 1'h1;
    slp();
    module_irq <= 1'h1;
    cyc(6);
    chk_mode(3'h1, "masked");
    axi_read(32'h4, rd, rsp);
    chk_word(rd, 32'hf1, "status");
    u_pins.nmi_flip();
    wait_mode(3'h0, n);
    chk_bit(ctrl.int_seq_start, 1'h1, "nmi wake");
    module_irq <= 1'h0;
    cpu_int_mask <= 1'h0;
    slp();
    u_pins.init_set(1'h0);
    cyc(4);
    chk_mode(3'h7, "init hold");
    u_pins.init_set(1'h1);
    wait_mode(3'h0, n);
    done("sleep");
    // Forbidden sources enabled on purpose to prove they are ignored
    irq_enable <= 8'hff;
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      bad = (seed[1:0] == 2'h3) ? 7 : 3 + seed[1:0];
      good = (seed[3:2] == 2'h3) ? 6 : seed[3:2];
      // Code 5 lasts one pass only, rewritten on the next
      // Clock is external, so the 8 ms crystal floor is not applied
      axi_write(32'h0, {24'h0, 1'h1, c[2:0], 1'h0, ~nmi_pin, 2'h1});
      slp();
      chk_mode(3'h3, "sw hw_standby_pin_n");
      chk_bit(ctrl.sysclk_enable, 1'h0, "clk stop");
      u_pins.irq_set(bad, 1'h0);
      cyc(4);
      chk_mode(3'h3, "no wake");
      u_pins.irq_set(bad, 1'h1);
      if (c[0]) u_pins.irq_set(good, 1'h0);
      else u_pins.nmi_flip();
      wait_mode(3'h2, n);
      wait_mode(3'h0, n);
      chk_word(n, settle_n(c[2:0]), "settle");
      chk_bit(ctrl.int_seq_start, 1'h1, "wake int");
      u_pins.irq_set(good, 1'h1);
      axi_read(32'h0, rd, rsp);
      chk_bit(rd[7], 1'h1, "select kept");
    end
    irq_enable <= 8'h47;
    axi_write(32'h0, 32'h81);
    slp();
    u_pins.init_set(1'h0);
    cyc(4);
    chk_mode(3'h7, "hw_standby_pin_n init");
    chk_bit(ctrl.osc_enable, 1'h1, "osc on");
    u_pins.init_set(1'h1);
    wait_mode(3'h0, n);
    chk_bit(ctrl.reset_seq_start, 1'h1, "reset seq");
    done("sw standby");
    for (int k = 0; k < 3; k++) begin
      axi_write(32'h0, (k == 1) ? 32'h80 : 32'h0);
      chk_bit(onchip_ram_enable, 1'h0, "ram off");
      if (k < 2) slp();
      u_pins.hw_enter(k == 2);
      cyc(4);
      chk_mode(3'h6, "hw hw_standby_pin_n");
      chk_bit(ctrl.io_hiz, 1'h1, "hi-z");
      chk_bit(ctrl.cpu_init, 1'h1, "cpu init");
      u_pins.hw_leave();
      wait_mode(3'h0, n);
      chk_bit(ctrl.reset_seq_start, 1'h1, "hw exit");
      axi_read(32'h0, rd, rsp);
      chk_word(rd, 32'h9, "regs reset");
    end
    done("hw standby");
    results();
  end
endmodule : tb_top
